// [hw/fsc_pkg.sv]
package fsc_pkg;
  // ---------------------------------------------------------------
  // register word offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] FREQ_SETTING_OFS = 8'h00;
  localparam logic [7:0] PROG_MODE_OFS = 8'h04;
  localparam logic [7:0] SEQ_COMMAND_OFS = 8'h08;
  localparam logic [7:0] ADDR_LOW_OFS = 8'h0C;
  localparam logic [7:0] ADDR_HIGH_OFS = 8'h10;
  localparam logic [7:0] END_LOW_OFS = 8'h14;
  localparam logic [7:0] END_HIGH_OFS = 8'h18;
  localparam logic [7:0] WBUF0_OFS = 8'h1C;
  localparam logic [7:0] WBUF1_OFS = 8'h20;
  localparam logic [7:0] WBUF2_OFS = 8'h24;
  localparam logic [7:0] WBUF3_OFS = 8'h28;
  localparam logic [7:0] SEQ_STATUS_OFS = 8'h2C;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] FREQ_RESET = 8'h00;
  localparam logic [7:0] FREQ_WMASK = 8'h1F;
  localparam logic [7:0] MODE_RESET = 8'h08;
  localparam logic [7:0] MODE_WMASK = 8'h2A;
  localparam int AREA_SELECT_POS = 5;
  localparam int INHIBIT_POS = 3;
  localparam int SELF_PROG_POS = 1;
  localparam int START_POS = 7;
  localparam logic [7:0] CMD_PROGRAM = 8'h81;
  localparam logic [7:0] CMD_ERASE = 8'h84;
  localparam logic [7:0] ADDR_HIGH_WMASK = 8'h7F;
  localparam logic [7:0] END_LOW_WMASK = 8'hFC;
  localparam logic [15:0] DATA_AREA_BASE = 16'h9000;
  localparam int SEQ_BUSY_CYCLES = 8;
  typedef enum logic [1:0] {ST_IDLE, ST_PROGRAM, ST_ERASE} fsc_state_type;
endpackage

// [hw/fsc_top.sv]
`timescale 1ns/10ps
// Overview of operation
// - program uses start address from pointer low and high registers
// - program data is the 32-bit word of four write buffer bytes
// - command write of 0x81 starts a one-word program
// - frequency field bits 4..0 hold MHz minus one
// - frequency register resets to zero, upper three bits read zero
// - mode register resets to 0x08; only bits 5, 3, 1 writable
// - bit 5 selects code area (0) or data area (1)
// - bit 3 high blocks programming and erase
// - bit 1 selects read mode (0) or self-programming mode (1)
// - command write of 0x84 starts a block erase
// - erase uses start pointer and end address registers
// - data-area offsets are relative to absolute 0x9000
module fsc_top
  import fsc_pkg::*;
#(
  parameter int BUSY_CYCLES = fsc_pkg::SEQ_BUSY_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flash_we,
  output logic flash_erase,
  output logic [15:0] flash_addr,
  output logic [15:0] flash_end_addr,
  output logic [31:0] flash_wdata,
  output logic [4:0] flash_freq_code
);
  import fsc_pkg::*;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic known;
  logic [7:0] wbyte;
  logic [7:0] freq_setting_reg;
  logic [7:0] prog_mode_control_reg;
  logic [7:0] seq_command_reg;
  logic [7:0] addr_pointer_low;
  logic [7:0] addr_pointer_high;
  logic [7:0] end_addr_low;
  logic [7:0] end_addr_high;
  logic [7:0] write_buf_byte0;
  logic [7:0] write_buf_byte1;
  logic [7:0] write_buf_byte2;
  logic [7:0] write_buf_byte3;
  logic done_reg;
  logic [7:0] rd_next;
  logic [15:0] rel_addr;
  logic [15:0] rel_end;
  logic cmd_wr;
  logic start_prog;
  logic start_erase;
  fsc_state_type state_reg;
  logic [15:0] cnt_reg;

  // setup cycle asserts pready so the access phase finishes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_comb begin
    wr_en = psel && penable && pready && pwrite;
    rd_en = psel && !penable && !pwrite;
    wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;
    case (paddr)
      FREQ_SETTING_OFS, PROG_MODE_OFS, SEQ_COMMAND_OFS, ADDR_LOW_OFS,
      ADDR_HIGH_OFS, END_LOW_OFS, END_HIGH_OFS, WBUF0_OFS, WBUF1_OFS,
      WBUF2_OFS, WBUF3_OFS, SEQ_STATUS_OFS: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // unmapped addresses answer with an error and change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !known;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // frequency reset and mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_setting_reg <= FREQ_RESET;
    end else if (wr_en && pstrb[0] && paddr == FREQ_SETTING_OFS) begin
      freq_setting_reg <= pwdata[7:0] & FREQ_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_mode_control_reg <= MODE_RESET;
    end else if (wr_en && pstrb[0] && paddr == PROG_MODE_OFS) begin
      prog_mode_control_reg <= pwdata[7:0] & MODE_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_pointer_low <= 8'h00;
      addr_pointer_high <= 8'h00;
      end_addr_low <= 8'h00;
      end_addr_high <= 8'h00;
      write_buf_byte0 <= 8'h00;
      write_buf_byte1 <= 8'h00;
      write_buf_byte2 <= 8'h00;
      write_buf_byte3 <= 8'h00;
    end else if (wr_en && pstrb[0]) begin
      case (paddr)
        ADDR_LOW_OFS: addr_pointer_low <= wbyte;
        ADDR_HIGH_OFS: addr_pointer_high <= wbyte & ADDR_HIGH_WMASK;
        END_LOW_OFS: end_addr_low <= wbyte & END_LOW_WMASK;
        END_HIGH_OFS: end_addr_high <= wbyte & ADDR_HIGH_WMASK;
        WBUF0_OFS: write_buf_byte0 <= wbyte;
        WBUF1_OFS: write_buf_byte1 <= wbyte;
        WBUF2_OFS: write_buf_byte2 <= wbyte;
        WBUF3_OFS: write_buf_byte3 <= wbyte;
        default: addr_pointer_low <= addr_pointer_low;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  always_comb begin
    cmd_wr = wr_en && pstrb[0] && paddr == SEQ_COMMAND_OFS;
    start_prog = cmd_wr && pwdata[7:0] == CMD_PROGRAM;
    start_erase = cmd_wr && pwdata[7:0] == CMD_ERASE;
    rel_addr = {addr_pointer_high, addr_pointer_low};
    rel_end = {end_addr_high, end_addr_low};
    if (prog_mode_control_reg[AREA_SELECT_POS]) begin
      rel_addr = rel_addr + DATA_AREA_BASE;
      rel_end = rel_end + DATA_AREA_BASE;
    end
  end

  // start bit self-clears when the sequencer goes idle again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_command_reg <= 8'h00;
    end else if (cmd_wr && state_reg == ST_IDLE) begin
      seq_command_reg <= pwdata[7:0];
    end else if (state_reg != ST_IDLE && cnt_reg == 16'h0001) begin
      seq_command_reg <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 16'h0000;
      done_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // inhibit blocks commands; only in self-programming
          if ((start_prog || start_erase) && !prog_mode_control_reg[INHIBIT_POS]
              && prog_mode_control_reg[SELF_PROG_POS]) begin
            state_reg <= start_prog ? ST_PROGRAM : ST_ERASE;
            cnt_reg <= 16'(BUSY_CYCLES);
            done_reg <= 1'b0;
          end
        end
        ST_PROGRAM, ST_ERASE: begin
          cnt_reg <= cnt_reg - 16'h0001;
          if (cnt_reg == 16'h0001) begin
            state_reg <= ST_IDLE;
            done_reg <= 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // array port latched at command start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_we <= 1'b0;
      flash_erase <= 1'b0;
      flash_addr <= 16'h0000;
      flash_end_addr <= 16'h0000;
      flash_wdata <= 32'h00000000;
    end else begin
      flash_we <= state_reg == ST_PROGRAM;
      flash_erase <= state_reg == ST_ERASE;
      if (state_reg == ST_IDLE) begin
        flash_addr <= rel_addr;
        flash_end_addr <= rel_end;
        flash_wdata <= {write_buf_byte3, write_buf_byte2, write_buf_byte1, write_buf_byte0};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_freq_code <= 5'h00;
    end else begin
      flash_freq_code <= freq_setting_reg[4:0];
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb begin
    case (paddr)
      FREQ_SETTING_OFS: rd_next = freq_setting_reg;
      PROG_MODE_OFS: rd_next = prog_mode_control_reg;
      SEQ_COMMAND_OFS: rd_next = seq_command_reg;
      ADDR_LOW_OFS: rd_next = addr_pointer_low;
      ADDR_HIGH_OFS: rd_next = addr_pointer_high;
      END_LOW_OFS: rd_next = end_addr_low;
      END_HIGH_OFS: rd_next = end_addr_high;
      WBUF0_OFS: rd_next = write_buf_byte0;
      WBUF1_OFS: rd_next = write_buf_byte1;
      WBUF2_OFS: rd_next = write_buf_byte2;
      WBUF3_OFS: rd_next = write_buf_byte3;
      SEQ_STATUS_OFS: rd_next = {6'h00, state_reg != ST_IDLE, done_reg};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= {24'h000000, rd_next};
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_freq_upper_zero;
    @(posedge pclk) disable iff (!presetn) freq_setting_reg[7:5] == 3'h0;
  endproperty
  a_freq_upper_zero: assert property (p_freq_upper_zero)
    else $error("freq upper bits set");

  property p_mode_fixed_zero;
    @(posedge pclk) disable iff (!presetn) (prog_mode_control_reg & ~MODE_WMASK) == 8'h00;
  endproperty
  a_mode_fixed_zero: assert property (p_mode_fixed_zero) else $error("mode ro bits set");

  sequence s_prog_cmd;
    start_prog && state_reg == ST_IDLE && !prog_mode_control_reg[INHIBIT_POS]
      && prog_mode_control_reg[SELF_PROG_POS];
  endsequence
  property p_prog_starts;
    @(posedge pclk) disable iff (!presetn) s_prog_cmd |=> state_reg == ST_PROGRAM ##1 flash_we;
  endproperty
  a_prog_starts: assert property (p_prog_starts) else $error("program not started");

  property p_erase_starts;
    @(posedge pclk) disable iff (!presetn)
      start_erase && state_reg == ST_IDLE && !prog_mode_control_reg[INHIBIT_POS]
      && prog_mode_control_reg[SELF_PROG_POS]
      |=> state_reg == ST_ERASE;
  endproperty
  a_erase_starts: assert property (p_erase_starts) else $error("erase not started");

  property p_bad_code_idle;
    @(posedge pclk) disable iff (!presetn)
      cmd_wr && state_reg == ST_IDLE && pwdata[7:0] != CMD_PROGRAM && pwdata[7:0] != CMD_ERASE
      |=> state_reg == ST_IDLE;
  endproperty
  a_bad_code_idle: assert property (p_bad_code_idle) else $error("bad code started");

  property p_inhibit_blocks;
    @(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE && prog_mode_control_reg[INHIBIT_POS] |=> state_reg == ST_IDLE;
  endproperty
  a_inhibit_blocks: assert property (p_inhibit_blocks) else $error("inhibit ignored");

  property p_read_mode_blocks;
    @(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE && !prog_mode_control_reg[SELF_PROG_POS] |=> state_reg == ST_IDLE;
  endproperty
  a_read_mode_blocks: assert property (p_read_mode_blocks)
    else $error("read mode ignored");

  property p_done_after;
    @(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE ##1 state_reg != ST_IDLE |-> ##[1:300] done_reg;
  endproperty
  a_done_after: assert property (p_done_after) else $error("done never set");

  sequence s_busy_end;
    state_reg != ST_IDLE ##1 state_reg == ST_IDLE;
  endsequence
  property p_done_at_end;
    @(posedge pclk) disable iff (!presetn) s_busy_end |-> done_reg;
  endproperty
  a_done_at_end: assert property (p_done_at_end) else $error("done not set at end");

  property p_data_rebase;
    @(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE && prog_mode_control_reg[AREA_SELECT_POS]
      |=> flash_addr == {addr_pointer_high, addr_pointer_low} + DATA_AREA_BASE
          || $past(cmd_wr) || $changed(addr_pointer_low) || $changed(addr_pointer_high);
  endproperty
  a_data_rebase: assert property (p_data_rebase) else $error("data base wrong");

  property p_wdata_word;
    @(posedge pclk) disable iff (!presetn)
      state_reg == ST_PROGRAM |-> flash_wdata[7:0] == write_buf_byte0 || $past(wr_en, 2);
  endproperty
  a_wdata_word: assert property (p_wdata_word) else $error("write word wrong");

endmodule // fsc_top

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
  import fsc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, flash_we, flash_erase;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, flash_wdata;
  logic [3:0] pstrb;
  logic [15:0] flash_addr, flash_end_addr;
  logic [4:0] flash_freq_code;
  logic err, seen;
  int n_mismatch, checks;

  // short busy count keeps each operation brief
  fsc_top #(.BUSY_CYCLES(4)) fsc_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_we(flash_we), .flash_erase(flash_erase),
    .flash_addr(flash_addr), .flash_end_addr(flash_end_addr),
    .flash_wdata(flash_wdata), .flash_freq_code(flash_freq_code)
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      $display("CHECK FAILED pready expected 1 seen 0");
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, exp, {24'h0, rd[7:0]});
  endtask

  // watch for the program or erase strobe within a fixed window
  task wait_op(input logic er, input logic exp);
    int i;
    seen = 1'b0;
    for (i = 0; i < 12; i++) begin
      @(posedge pclk);
      if ((er ? flash_erase : flash_we) === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    check(er ? "erase_start" : "program_start", {31'h0, exp}, {31'h0, seen});
  endtask

  task wait_done;
    int i;
    for (i = 0; i < 30; i++) begin
      apb(1'b0, SEQ_STATUS_OFS, 32'h0);
      if (rd[0] === 1'b1) break;
    end
    check("done_flag", 32'h1, {31'h0, rd[0]});
  endtask

  task load(input logic [7:0] lo, input logic [7:0] hi, input logic [31:0] w);
    apb(1'b1, ADDR_LOW_OFS, {24'h0, lo});
    apb(1'b1, ADDR_HIGH_OFS, {24'h0, hi});
    apb(1'b1, WBUF0_OFS, {24'h0, w[7:0]});
    apb(1'b1, WBUF1_OFS, {24'h0, w[15:8]});
    apb(1'b1, WBUF2_OFS, {24'h0, w[23:16]});
    apb(1'b1, WBUF3_OFS, {24'h0, w[31:24]});
  endtask

  // no test may hang the run
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    test_done();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    n_mismatch = 0;
    checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("freq_reset", FREQ_SETTING_OFS, 32'h00);
    rd_chk("mode_reset", PROG_MODE_OFS, 32'h08);
    $display("test reset_values done");
    apb(1'b1, FREQ_SETTING_OFS, 32'hFF);
    rd_chk("freq_mask", FREQ_SETTING_OFS, 32'h1F);
    check("freq_code_max", 32'h1F, {27'h0, flash_freq_code});
    apb(1'b1, FREQ_SETTING_OFS, 32'h04);
    // code output lags the register by one clock
    repeat (2) @(posedge pclk);
    check("freq_code_5mhz", 32'h04, {27'h0, flash_freq_code});
    apb(1'b1, PROG_MODE_OFS, 32'hFF);
    rd_chk("mode_mask", PROG_MODE_OFS, 32'h2A);
    check("mapped_err", 32'h0, {31'h0, err});
    apb(1'b0, 8'h30, 32'h0);
    check("unmapped_err", 32'h1, {31'h0, err});
    $display("test access_kinds done");
    // inhibit set: command must not start
    load(8'h34, 8'h12, 32'h44332211);
    apb(1'b1, PROG_MODE_OFS, 32'h0A);
    apb(1'b1, SEQ_COMMAND_OFS, {24'h0, CMD_PROGRAM});
    wait_op(1'b0, 1'b0);
    apb(1'b1, PROG_MODE_OFS, 32'h00);
    apb(1'b1, SEQ_COMMAND_OFS, {24'h0, CMD_PROGRAM});
    wait_op(1'b0, 1'b0);
    apb(1'b1, PROG_MODE_OFS, 32'h02);
    apb(1'b1, SEQ_COMMAND_OFS, 32'h82);
    wait_op(1'b0, 1'b0);
    $display("test refusals done");
    apb(1'b1, SEQ_COMMAND_OFS, {24'h0, CMD_PROGRAM});
    wait_op(1'b0, 1'b1);
    check("code_addr", 32'h1234, {16'h0, flash_addr});
    check("code_data", 32'h44332211, flash_wdata);
    wait_done();
    $display("test program_code done");
    apb(1'b1, PROG_MODE_OFS, 32'h22);
    load(8'h10, 8'h00, 32'h3CC35AA5);
    apb(1'b1, SEQ_COMMAND_OFS, {24'h0, CMD_PROGRAM});
    wait_op(1'b0, 1'b1);
    check("data_addr", 32'h9010, {16'h0, flash_addr});
    check("data_word", 32'h3CC35AA5, flash_wdata);
    wait_done();
    $display("test program_data done");
    apb(1'b1, ADDR_LOW_OFS, 32'h00);
    apb(1'b1, ADDR_HIGH_OFS, 32'h02);
    apb(1'b1, END_LOW_OFS, 32'hFF);
    apb(1'b1, END_HIGH_OFS, 32'h03);
    rd_chk("end_low_mask", END_LOW_OFS, 32'hFC);
    apb(1'b1, SEQ_COMMAND_OFS, {24'h0, CMD_ERASE});
    wait_op(1'b1, 1'b1);
    check("erase_start_addr", 32'h9200, {16'h0, flash_addr});
    check("erase_end_addr", 32'h93FC, {16'h0, flash_end_addr});
    wait_done();
    apb(1'b1, PROG_MODE_OFS, 32'h08);
    rd_chk("mode_locked", PROG_MODE_OFS, 32'h08);
    $display("test erase_data done");
    // a second reset after use must clear what software set
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("freq_rereset", FREQ_SETTING_OFS, 32'h00);
    rd_chk("status_rereset", SEQ_STATUS_OFS, 32'h00);
    check("freq_code_rereset", 32'h0, {27'h0, flash_freq_code});
    $display("test mid_reset done");
    test_done();
  end
endmodule // tb
